/* hdl/fmt_pkg.sv */
// fmt_pkg: constants for the fsk modem tone control block
// assumes a 10 MHz system clock standing in for the crystal-derived clock
package fmt_pkg;
  // system clock rate in hertz
  localparam int unsigned CLK_HZ = 10_000_000;
  // tone frequencies in hertz
  localparam int unsigned ORIG_SPACE_HZ = 1070;
  localparam int unsigned ORIG_MARK_HZ = 1270;
  localparam int unsigned ANS_SPACE_HZ = 2025;
  localparam int unsigned ANS_MARK_HZ = 2225;
  // phase accumulator width; one step adds the tone's phase increment
  localparam int unsigned PHASE_W = 24;
  // phase increment = freq * 2^PHASE_W / CLK_HZ, rounded to nearest in 64 bits
  // so the tone error stays well inside a few hertz
  localparam logic [PHASE_W-1:0] INC_ORIG_SPACE =
    PHASE_W'(((64'(ORIG_SPACE_HZ) << PHASE_W) + 64'(CLK_HZ / 2)) / 64'(CLK_HZ));
  localparam logic [PHASE_W-1:0] INC_ORIG_MARK =
    PHASE_W'(((64'(ORIG_MARK_HZ) << PHASE_W) + 64'(CLK_HZ / 2)) / 64'(CLK_HZ));
  localparam logic [PHASE_W-1:0] INC_ANS_SPACE =
    PHASE_W'(((64'(ANS_SPACE_HZ) << PHASE_W) + 64'(CLK_HZ / 2)) / 64'(CLK_HZ));
  localparam logic [PHASE_W-1:0] INC_ANS_MARK =
    PHASE_W'(((64'(ANS_MARK_HZ) << PHASE_W) + 64'(CLK_HZ / 2)) / 64'(CLK_HZ));
  // carrier timing factors in microseconds per microfarad
  localparam int unsigned ON_MS_PER_UF = 6400;
  localparam int unsigned OFF_MS_PER_UF = 540;
  // default timing capacitance in nanofarads
  localparam int unsigned CAP_NF = 100;
  // derived cycle counts: us/uF*nF/1000 -> us ; us*10 cycles
  localparam longint unsigned ON_CYCLES =
    (64'(ON_MS_PER_UF) * 64'(CAP_NF) * 64'(CLK_HZ)) / 64'd1_000_000_000;
  localparam longint unsigned OFF_CYCLES =
    (64'(OFF_MS_PER_UF) * 64'(CAP_NF) * 64'(CLK_HZ)) / 64'd1_000_000_000;
  localparam int unsigned TMR_W = 32;
  // sine table resolution
  localparam int unsigned SINE_W = 8;
  localparam logic [SINE_W-1:0] SINE_MID = 8'h80;
endpackage

/* hdl/fmt_tone_control.sv */
// fmt_tone_control: transmit tone synthesis, receive decision, carrier
// qualification and loopback/squelch/power-down control of an fsk modem.
// assumes analog front end supplies mark/space energy levels and a
// carrier level compare pair from outside; all those inputs are async.
// Functional notes
// - one of four tones, chosen by mode select and transmit bit
// - originate: send 1070/1270 Hz, receive 2025/2225 Hz
// - answer: send 2025/2225 Hz, receive 1070/1270 Hz
// - tones made by dividing clock; divisor reprogrammed on tone change
// - frequency switches at once and stays phase continuous
// - clock from crystal or external clock of that frequency
// - received data high when mark energy exceeds space energy
// - loop select high feeds modulator back into demodulator
// - squelch high mutes modulator; external tone path stays active
// - loop select and squelch both high enter power-down
// - carrier indication goes low after signal qualified for on-delay
// - indication returns high after absence for off-delay
// - threshold drops 3 dB when carrier found, rises when lost
`default_nettype none
module fmt_tone_control #(
  parameter longint unsigned ON_CYC = fmt_pkg::ON_CYCLES,
  parameter longint unsigned OFF_CYC = fmt_pkg::OFF_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic originate_sel,
  input wire logic tx_data,
  input wire logic analog_loop_select,
  input wire logic transmit_squelch,
  input wire logic rx_mark_above_space,
  input wire logic line_above_high_thr,
  input wire logic line_above_low_thr,
  input wire logic external_tone_input,
  output logic [fmt_pkg::SINE_W-1:0] tx_sample,
  output logic tx_tone_sq,
  output logic tx_line_tone,
  output logic rx_data,
  output logic carrier_present_n,
  output logic carrier_threshold_low,
  output logic power_down
);
  import fmt_pkg::*;

  localparam logic [TMR_W-1:0] ON_N = TMR_W'(ON_CYC);
  localparam logic [TMR_W-1:0] OFF_N = TMR_W'(OFF_CYC);

  // synchronised copies of the pin inputs; all logic below reads only these
  logic orig_s;
  logic txd_s;
  logic loop_s;
  logic sq_s;
  logic mark_s;
  logic hi_thr_s;
  logic lo_thr_s;
  logic ext_s;

  // mode select from the host: high originate, low answer
  fmt_sync2 #(.RESET_VAL(1'b0)) u_sync_orig (
    .clk(clk),
    .rst_n(rst_n),
    .d(originate_sel),
    .q(orig_s)
  );

  // transmit data bit: high mark, low space
  fmt_sync2 #(.RESET_VAL(1'b0)) u_sync_txd (
    .clk(clk),
    .rst_n(rst_n),
    .d(tx_data),
    .q(txd_s)
  );

  // loop select; together with squelch it means power-down
  fmt_sync2 #(.RESET_VAL(1'b0)) u_sync_loop (
    .clk(clk),
    .rst_n(rst_n),
    .d(analog_loop_select),
    .q(loop_s)
  );

  // squelch request for the modulator
  fmt_sync2 #(.RESET_VAL(1'b0)) u_sync_sq (
    .clk(clk),
    .rst_n(rst_n),
    .d(transmit_squelch),
    .q(sq_s)
  );

  // discriminator verdict from the analog side
  fmt_sync2 #(.RESET_VAL(1'b0)) u_sync_mark (
    .clk(clk),
    .rst_n(rst_n),
    .d(rx_mark_above_space),
    .q(mark_s)
  );

  // line level against the acquire threshold
  fmt_sync2 #(.RESET_VAL(1'b0)) u_sync_hi (
    .clk(clk),
    .rst_n(rst_n),
    .d(line_above_high_thr),
    .q(hi_thr_s)
  );

  // line level against the threshold 3 dB lower
  fmt_sync2 #(.RESET_VAL(1'b0)) u_sync_lo (
    .clk(clk),
    .rst_n(rst_n),
    .d(line_above_low_thr),
    .q(lo_thr_s)
  );

  // external tone stand-in; kept apart from the modulator path
  fmt_sync2 #(.RESET_VAL(1'b0)) u_sync_ext (
    .clk(clk),
    .rst_n(rst_n),
    .d(external_tone_input),
    .q(ext_s)
  );

  // mode decode
  wire pd = loop_s & sq_s;
  wire loop_on = loop_s & ~sq_s;
  wire mute = sq_s;

  // tone selection: mark when bit high mode picks the band
  logic [PHASE_W-1:0] inc_sel;
  always_comb begin
    unique case ({orig_s, txd_s})
      2'b10: inc_sel = INC_ORIG_SPACE;
      2'b11: inc_sel = INC_ORIG_MARK;
      2'b00: inc_sel = INC_ANS_SPACE;
      2'b01: inc_sel = INC_ANS_MARK;
    endcase
  end

  // accumulating divider; increment swaps without resetting phase so the
  // waveform never jumps when the data bit changes
  logic [PHASE_W-1:0] phase_q;
  logic [PHASE_W-1:0] phase_d;
  assign phase_d = pd ? phase_q : phase_q + inc_sel;
  // one step per system clock, which stands in for the crystal clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) phase_q <= '0;
    else phase_q <= phase_d;
  end

  // coarse sine from top phase bits: 32-entry quarter wave table; finer
  // steps push the sampling images further from the tone itself, at the
  // cost of a larger table
  logic [4:0] qidx;
  logic [6:0] qmag;
  wire [1:0] quad = phase_q[PHASE_W-1 -: 2];
  // odd quadrants read the table backwards
  assign qidx = quad[0] ? ~phase_q[PHASE_W-3 -: 5] : phase_q[PHASE_W-3 -: 5];
  always_comb begin
    unique case (qidx)
      5'h00: qmag = 7'h03;
      5'h01: qmag = 7'h09;
      5'h02: qmag = 7'h10;
      5'h03: qmag = 7'h16;
      5'h04: qmag = 7'h1C;
      5'h05: qmag = 7'h22;
      5'h06: qmag = 7'h28;
      5'h07: qmag = 7'h2E;
      5'h08: qmag = 7'h33;
      5'h09: qmag = 7'h39;
      5'h0A: qmag = 7'h3F;
      5'h0B: qmag = 7'h44;
      5'h0C: qmag = 7'h49;
      5'h0D: qmag = 7'h4E;
      5'h0E: qmag = 7'h53;
      5'h0F: qmag = 7'h58;
      5'h10: qmag = 7'h5C;
      5'h11: qmag = 7'h60;
      5'h12: qmag = 7'h64;
      5'h13: qmag = 7'h68;
      5'h14: qmag = 7'h6B;
      5'h15: qmag = 7'h6E;
      5'h16: qmag = 7'h71;
      5'h17: qmag = 7'h74;
      5'h18: qmag = 7'h76;
      5'h19: qmag = 7'h79;
      5'h1A: qmag = 7'h7A;
      5'h1B: qmag = 7'h7C;
      5'h1C: qmag = 7'h7D;
      5'h1D: qmag = 7'h7E;
      5'h1E: qmag = 7'h7F;
      5'h1F: qmag = 7'h7F;
    endcase
  end
  // second half-cycle below mid scale, first half above
  wire [SINE_W-1:0] sine_val = quad[1] ? SINE_MID - {1'b0, qmag} : SINE_MID + {1'b0, qmag};
  wire tone_sq = ~phase_q[PHASE_W-1];

  // receive source: own modulator in loopback, else line discriminator
  wire rx_dec = loop_on ? txd_s : mark_s;

  // carrier qualification with hysteresis between two thresholds
  logic carrier_q;
  logic [TMR_W-1:0] tmr_q;
  wire sig_ok = carrier_q ? lo_thr_s : hi_thr_s;
  wire pending = carrier_q ? ~sig_ok : sig_ok;
  wire [TMR_W-1:0] limit = carrier_q ? OFF_N : ON_N;
  wire expire = pending && (tmr_q >= limit - TMR_W'(1));

  // next carrier state and timer; the timer restarts whenever the signal
  // goes back to the held state, so a short dropout never counts
  logic carrier_d;
  logic [TMR_W-1:0] tmr_d;
  assign carrier_d = pd ? 1'b0 : (expire ? ~carrier_q : carrier_q);
  assign tmr_d = (pd || expire || !pending) ? '0 : tmr_q + TMR_W'(1);

  // carrier state and its qualification timer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      carrier_q <= 1'b0;
      tmr_q <= '0;
    end else begin
      carrier_q <= carrier_d;
      tmr_q <= tmr_d;
    end
  end

  // transmit output values; loopback also keeps the line quiet
  wire tx_quiet = mute || loop_on;
  wire [SINE_W-1:0] tx_sample_d = tx_quiet ? SINE_MID : sine_val;
  wire tx_tone_sq_d = tx_quiet ? 1'b0 : tone_sq;
  // external tones reach the line driver whatever the modulator does
  wire tx_line_tone_d = tx_tone_sq_d | ext_s;
  // powered down the data pin has no driver; here it simply rests high
  wire rx_data_d = pd ? 1'b1 : rx_dec;

  // registered transmit outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_sample <= SINE_MID;
      tx_tone_sq <= 1'b0;
      tx_line_tone <= 1'b0;
    end else begin
      tx_sample <= tx_sample_d;
      tx_tone_sq <= tx_tone_sq_d;
      tx_line_tone <= tx_line_tone_d;
    end
  end

  // registered receive and status outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_data <= 1'b1;
      carrier_present_n <= 1'b1;
      carrier_threshold_low <= 1'b0;
      power_down <= 1'b0;
    end else begin
      rx_data <= rx_data_d;
      carrier_present_n <= ~carrier_q;
      carrier_threshold_low <= carrier_q;
      power_down <= pd;
    end
  end
endmodule

// fmt_sync2: two-stage synchroniser for one asynchronous level input
// only the second stage feeds logic; the first may go metastable
module fmt_sync2 #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic d,
  output logic q
);
  logic meta_q;

  // both stages clear together so no false edge follows reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= RESET_VAL;
      q <= RESET_VAL;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule
`default_nettype wire

/* sim/fmt_tone_control_monitor.sv */
// checker bound to fmt_tone_control, watching its ports only
// assumes every input is held at least five cycles per step
`default_nettype none
module fmt_tone_control_monitor
  import fmt_pkg::*;
#(
  parameter longint unsigned ON_CYC = 20,
  parameter longint unsigned OFF_CYC = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tx_data,
  input wire logic analog_loop_select,
  input wire logic transmit_squelch,
  input wire logic rx_mark_above_space,
  input wire logic line_above_high_thr,
  input wire logic line_above_low_thr,
  input wire logic external_tone_input,
  input wire logic [fmt_pkg::SINE_W-1:0] tx_sample,
  input wire logic tx_tone_sq,
  input wire logic tx_line_tone,
  input wire logic rx_data,
  input wire logic carrier_present_n,
  input wire logic carrier_threshold_low,
  input wire logic power_down
);
  logic [31:0] hi_q, lo_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // run lengths of high-threshold presence and low-threshold absence; any break restarts them
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hi_q <= '0;
      lo_q <= '0;
    end else begin
      hi_q <= line_above_high_thr ? hi_q + 1 : '0;
      lo_q <= line_above_low_thr ? '0 : lo_q + 1;
    end
  end
  on_delay_a: assert property ($fell(carrier_present_n) |-> hi_q >= ON_CYC) else $error("early");
  on_bound_a: assert property (hi_q == ON_CYC + 6 && !power_down |-> !carrier_present_n) else $error("late");
  off_delay_a: assert property ($rose(carrier_present_n) && !power_down |-> lo_q >= OFF_CYC) else $error("drop");
  thr_track_a: assert property ($stable(carrier_present_n) |-> carrier_threshold_low == !carrier_present_n) else $error("thr");
  pd_enter_a: assert property ((analog_loop_select && transmit_squelch) [*5] |-> power_down && carrier_present_n) else $error("pd");
  sq_mute_a: assert property (transmit_squelch [*5] |-> tx_sample == SINE_MID && !tx_tone_sq) else $error("mute");
  ext_path_a: assert property ((external_tone_input && !analog_loop_select) [*5] |-> tx_line_tone) else $error("ext");
  rx_decide_a: assert property ((!analog_loop_select && $stable(rx_mark_above_space)) [*5] |-> rx_data == rx_mark_above_space) else $error("rx");
  loop_back_a: assert property ((analog_loop_select && !transmit_squelch && $stable(tx_data)) [*5] |-> rx_data == tx_data) else $error("loop");
  cover property (power_down);
  cover property ($fell(carrier_present_n));
  cover property ($rose(rx_data));
endmodule
bind fmt_tone_control fmt_tone_control_monitor #(.ON_CYC(ON_CYC), .OFF_CYC(OFF_CYC)) mon (.*);
`default_nettype wire

/* sim/fmt_far_modem.sv */
// far modem as seen through the analog front end
// assumes level 0 none, 1 between thresholds, 2 strong
`default_nettype none
module fmt_far_modem (
  input wire logic clk,
  input wire logic [1:0] level,
  input wire logic send_mark,
  output logic rx_mark_above_space,
  output logic line_above_high_thr,
  output logic line_above_low_thr
);
  logic n_q = 1'b0;
  // no carrier: discriminator gives noise flipping every cycle
  always_ff @(negedge clk) n_q <= !n_q;
  assign rx_mark_above_space = level != 2'h0 ? send_mark : n_q;
  assign line_above_high_thr = level == 2'h2;
  assign line_above_low_thr = level != 2'h0;
endmodule
`default_nettype wire

/* sim/fmt_tone_control_test.sv */
// self-checking bench for fmt_tone_control with a far modem model
// assumes short carrier timers (20 and 8 cycles) for quick runs
`default_nettype none
module fmt_tone_control_test;
  timeunit 1ns;
  timeprecision 1ns;
  import fmt_pkg::*;
  logic clk = 0, rst_n = 0, originate_sel = 0, tx_data = 0, analog_loop_select = 0;
  logic transmit_squelch = 0, external_tone_input = 0, send_mark = 0, tp;
  logic [1:0] level = 0;
  logic rx_mark_above_space, line_above_high_thr, line_above_low_thr, tx_tone_sq;
  logic tx_line_tone, rx_data, carrier_present_n, carrier_threshold_low, power_down;
  logic [7:0] tx_sample;
  int errors = 0, comparisons = 0, seed = 60711, n, c, f;
  fmt_far_modem far (.*);
  fmt_tone_control #(.ON_CYC(20), .OFF_CYC(8)) dut (.*);
  // 10 MHz stand-in for the crystal clock
  initial forever #50 clk = !clk;
  always @(posedge clk) tp <= tx_tone_sq;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic w(input int k);
    repeat (k) @(negedge clk);
  endtask
  // next rising tone edge, bounded so a stuck tone cannot hang
  task automatic rise;
    int k;
    for (k = 0; k < 12000; k++) begin
      w(1);
      c++;
      if (tx_tone_sq && !tp) return;
    end
    errors++;
    report_and_stop();
  endtask
  function automatic int hz(input int o, input int d);
    return o ? (d ? ORIG_MARK_HZ : ORIG_SPACE_HZ) : (d ? ANS_MARK_HZ : ANS_SPACE_HZ);
  endfunction
  initial begin
    w(8);
    check({tx_sample, tx_tone_sq, tx_line_tone, rx_data, carrier_present_n,
      carrier_threshold_low, power_down}, {SINE_MID, 6'b001100});
    rst_n = 1;
    // carrier with a dropout that restarts the count, then hysteresis
    level = 2; w(15); level = 0; w(2); level = 2; w(18);
    check(carrier_present_n, 1);
    w(8);
    check({carrier_present_n, carrier_threshold_low}, 2'b01);
    level = 1; w(40);
    check(carrier_present_n, 0);
    level = 0; w(6);
    check(carrier_present_n, 0);
    w(8);
    check({carrier_present_n, carrier_threshold_low}, 2'b10);
    // four tones; mode select high means originate
    for (n = 0; n < 4; n++) begin
      originate_sel = n[1];
      tx_data = n[0];
      w(6); rise(); c = 0; rise();
      f = CLK_HZ / hz(n[1], n[0]);
      check(c > f - 3 && c < f + 3, 1);
    end
    // random data from the far end, then looped back locally
    level = 2;
    for (n = 0; n < 40; n++) begin
      analog_loop_select = n >= 20;
      send_mark = 1'($random(seed));
      tx_data = 1'($random(seed));
      w(5);
      check(rx_data, analog_loop_select ? tx_data : send_mark);
    end
    analog_loop_select = 0; transmit_squelch = 1; external_tone_input = 1; w(5);
    check({tx_sample, tx_tone_sq, tx_line_tone}, {SINE_MID, 2'b01});
    analog_loop_select = 1; w(5);
    check({power_down, carrier_present_n, rx_data}, 3'b111);
    c = tx_sample; w(40);
    check(tx_sample, c[7:0]);
    check(carrier_present_n, 1);
    report_and_stop();
  end
endmodule
`default_nettype wire
